// ### core/adc_pipeline_output_port.v
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "adc_port_map.vh"

// Functional notes
// R1: new sample taken on rising edge of encode, encode_pos above encode_neg.
// R2: code appears five encode cycles after its capturing edge.
// R3: power select low, enable low: convert and drive outputs.
// R4: power select low, enable high: convert, outputs high impedance.
// R5: power select high, enable low: nap, outputs high impedance.
// R6: both high: sleep, outputs high impedance.
// R7: capture logic latches code and flag on strobe falling edge.
// R8: ten-bit word, highest bit is most significant.
// R9: range flag high with words whose sample clipped.
// R10: four-level select picks coding and stabiliser setting.
// R11: track while encode low, hold at rising edge.
// R12: two's complement mid-scale flickers all zeros and all ones.
// R13: word, flag and strobe update together once per encode cycle.
// R14: capture logic ignores outputs when disabled; discards five words after resuming (capture_model only gates on live_i and discards none).
module adc_pipeline_output_port #(
	parameter CODE_W  = `CODE_WIDTH,
	parameter LATENCY = `PIPE_LATENCY
) (
	input  wire              ref_clk_i,
	input  wire              reset_i,
	input  wire              encode_pos_i,
	input  wire              encode_neg_i,
	input  wire [CODE_W-1:0] analog_code_i,
	input  wire              analog_over_i,
	input  wire              analog_under_i,
	input  wire              power_down_select_i,
	input  wire              output_enable_n_i,
	input  wire [1:0]        format_select_i,
	input  wire [3:0]        reg_addr_i,
	input  wire [7:0]        reg_wdata_i,
	input  wire              reg_write_i,
	input  wire              reg_read_i,
	output reg  [7:0]        reg_rdata_o,
	output reg  [CODE_W-1:0] sample_code_bits_o,
	output reg  [CODE_W-1:0] sample_code_bits_oe_o,
	output reg               range_flag_o,
	output reg               range_flag_oe_o,
	output reg               data_valid_strobe_o,
	output reg               data_valid_strobe_oe_o,
	output reg               twos_complement_o,
	output reg               stabiliser_on_o,
	output reg  [1:0]        power_state_o,
	output reg               irq_o
);
	// ---------------------------------------------------------------
	// input synchronisation
	// ---------------------------------------------------------------
	localparam SW = CODE_W + 8;
	wire [SW-1:0] sync_w;
	wire          enc_s;
	wire [CODE_W-1:0] code_s;
	wire          over_s;
	wire          under_s;
	wire          pd_s;
	wire          oen_s;
	wire [1:0]    fmt_s;

	// every pin except the register port crosses two flops; the analog code is assumed quasi-static
	// relative to the fast clock, so per-bit skew is tolerated
	// both encode legs cross on their own: comparing the raw legs would let
	// a skew glitch between them reach the edge detector
	sync2 #(
		.WIDTH (SW)
	) u_sync (
		.ref_clk_i (ref_clk_i),
		.reset_i   (reset_i),
		.async_i   ({encode_pos_i, encode_neg_i, analog_code_i, analog_over_i,
		             analog_under_i, power_down_select_i, output_enable_n_i,
		             format_select_i}),
		.sync_o    (sync_w)
	);
	// R1: encode high is positive leg up, negative leg down
	assign enc_s   = sync_w[SW-1] & ~sync_w[SW-2];
	assign code_s  = sync_w[SW-3:6];
	assign over_s  = sync_w[5];
	assign under_s = sync_w[4];
	assign pd_s    = sync_w[3];
	assign oen_s   = sync_w[2];
	assign fmt_s   = sync_w[1:0];

	// ---------------------------------------------------------------
	// encode edge detect and track/hold
	// ---------------------------------------------------------------
	reg          enc_q;
	reg [CODE_W-1:0] held_code_q;
	reg          held_range_q;
	wire         enc_rise;
	wire         enc_fall;
	wire         converting;

	assign enc_rise   = enc_s & ~enc_q;
	assign enc_fall   = ~enc_s & enc_q;
	assign converting = ~pd_s;

	// R11: track then hold
	always @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			enc_q        <= 1'b0;
			held_code_q  <= {CODE_W{1'b0}};
			held_range_q <= 1'b0;
		end else begin
			enc_q <= enc_s;
			// R1: capture on rising encode
			if (enc_rise && converting) begin
				held_code_q  <= code_s;
				held_range_q <= over_s | under_s;
			end
		end
	end

	// ---------------------------------------------------------------
	// format decode
	// ---------------------------------------------------------------
	reg fmt_twos;
	reg fmt_stab;
	// R10: four-level select decode
	always @* begin
		fmt_twos = 1'b0;
		fmt_stab = 1'b0;
		case (fmt_s)
			`FMT_GND: begin
				fmt_twos = 1'b0;
				fmt_stab = 1'b0;
			end
			`FMT_THIRD: begin
				fmt_twos = 1'b0;
				fmt_stab = 1'b1;
			end
			`FMT_TWO_THIRDS: begin
				fmt_twos = 1'b1;
				fmt_stab = 1'b1;
			end
			default: begin
				fmt_twos = 1'b1;
				fmt_stab = 1'b0;
			end
		endcase
	end

	// R12: two's complement flips msb so mid-scale toggles zeros and ones
	wire [CODE_W-1:0] coded;
	assign coded = fmt_twos ? {~held_code_q[CODE_W-1], held_code_q[CODE_W-2:0]}
	                        : held_code_q;

	// ---------------------------------------------------------------
	// pipeline of latency stages
	// ---------------------------------------------------------------
	reg [CODE_W:0] pipe_q [0:LATENCY-1];
	genvar gi;
	// R2: fixed latency, stage advance per encode rise
	generate
		for (gi = 0; gi < LATENCY; gi = gi + 1) begin : g_pipe
			wire [CODE_W:0] stage_in;
			// head stage loads the held sample, later stages copy the one before
			if (gi == 0) begin : g_head
				assign stage_in = {held_range_q, coded};
			end else begin : g_body
				assign stage_in = pipe_q[gi-1];
			end
			always @(posedge ref_clk_i or posedge reset_i) begin
				if (reset_i) begin
					pipe_q[gi] <= {(CODE_W+1){1'b0}};
				end else if (enc_rise && converting) begin
					pipe_q[gi] <= stage_in;
				end
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// power state
	// ---------------------------------------------------------------
	reg [1:0] pwr_d;
	// R3: normal
	// R4: converting, outputs off
	// R5: nap
	// R6: sleep
	always @* begin
		case ({pd_s, oen_s})
			2'h0:    pwr_d = `PWR_NORMAL;
			2'h1:    pwr_d = `PWR_HIZ;
			2'h2:    pwr_d = `PWR_NAP;
			default: pwr_d = `PWR_SLEEP;
		endcase
	end
	wire drive_en;
	assign drive_en = (pwr_d == `PWR_NORMAL);

	// ---------------------------------------------------------------
	// output stage
	// ---------------------------------------------------------------
	reg [3:0] warm_q;
	// R13: word, flag and strobe move together; strobe falls at encode rise
	always @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			sample_code_bits_o     <= {CODE_W{1'b0}};
			sample_code_bits_oe_o  <= {CODE_W{1'b0}};
			range_flag_o           <= 1'b0;
			range_flag_oe_o        <= 1'b0;
			data_valid_strobe_o    <= 1'b0;
			data_valid_strobe_oe_o <= 1'b0;
			twos_complement_o      <= 1'b0;
			stabiliser_on_o        <= 1'b0;
			power_state_o          <= `PWR_SLEEP;
		end else begin
			twos_complement_o      <= fmt_twos;
			stabiliser_on_o        <= fmt_stab;
			power_state_o          <= pwr_d;
			sample_code_bits_oe_o  <= {CODE_W{drive_en}};
			range_flag_oe_o        <= drive_en;
			data_valid_strobe_oe_o <= drive_en;
			// strobe is encode inverted so its falling edge follows new data by half a cycle
			if (enc_fall) begin
				data_valid_strobe_o <= 1'b1;
			end else if (enc_rise) begin
				data_valid_strobe_o <= 1'b0;
			end
			// R8: msb in top bit
			// R9: range flag with its word
			if (enc_fall && converting) begin
				sample_code_bits_o <= pipe_q[LATENCY-1][CODE_W-1:0];
				range_flag_o       <= pipe_q[LATENCY-1][CODE_W];
			end
		end
	end

	// ---------------------------------------------------------------
	// resume tracking: counts encode cycles after leaving nap or sleep
	// ---------------------------------------------------------------
	reg  pd_q;
	wire resume_evt;
	assign resume_evt = pd_q & ~pd_s;
	// R14: flag words that capture logic should discard
	always @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			pd_q   <= 1'b0;
			warm_q <= 4'h0;
		end else begin
			pd_q <= pd_s;
			if (resume_evt) begin
				warm_q <= LATENCY[3:0];
			end else if (enc_rise && converting && warm_q != 4'h0) begin
				warm_q <= warm_q - 4'h1;
			end
		end
	end

	// ---------------------------------------------------------------
	// registers and interrupt
	// ---------------------------------------------------------------
	reg [`ST_WIDTH-1:0] status_q;
	reg [`ST_WIDTH-1:0] mask_q;
	reg [7:0]           count_q;
	wire [`ST_WIDTH-1:0] evt;
	wire [`ST_WIDTH-1:0] clr;
	assign evt[`ST_RANGE]  = enc_fall & converting & pipe_q[LATENCY-1][CODE_W];
	assign evt[`ST_RESUME] = resume_evt;
	assign clr = (reg_write_i && reg_addr_i == `REG_STATUS) ?
	             reg_wdata_i[`ST_WIDTH-1:0] : {`ST_WIDTH{1'b0}};

	// sticky status, set wins over clear
	always @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			status_q <= {`ST_WIDTH{1'b0}};
			mask_q   <= `MASK_RESET;
			count_q  <= 8'h00;
			irq_o    <= 1'b0;
		end else begin
			status_q <= (status_q & ~clr) | evt;
			if (reg_write_i && reg_addr_i == `REG_MASK) begin
				mask_q <= reg_wdata_i[`ST_WIDTH-1:0];
			end
			if (evt[`ST_RANGE] && count_q != 8'hFF) begin
				count_q <= count_q + 8'h01;
			end
			irq_o <= |(((status_q & ~clr) | evt) & mask_q);
		end
	end

	// read data one cycle after strobe, zero otherwise
	always @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_read_i) begin
			case (reg_addr_i)
				`REG_STATUS: reg_rdata_o <= {6'h00, status_q};
				`REG_MASK:   reg_rdata_o <= {6'h00, mask_q};
				`REG_STATE:  reg_rdata_o <= {warm_q, fmt_stab, fmt_twos, pwr_d};
				`REG_COUNT:  reg_rdata_o <= count_q;
				default:     reg_rdata_o <= 8'h00;
			endcase
		end else begin
			reg_rdata_o <= 8'h00;
		end
	end
endmodule
`default_nettype wire

// ### core/adc_port_map.vh
`ifndef ADC_PORT_MAP_VH
`define ADC_PORT_MAP_VH
// ---------------------------------------------------------------
// widths and latency
// ---------------------------------------------------------------
`define CODE_WIDTH        10
`define PIPE_LATENCY      5
// ---------------------------------------------------------------
// format select levels (two-bit digitised four-level pin)
// ---------------------------------------------------------------
`define FMT_GND           2'h0
`define FMT_THIRD         2'h1
`define FMT_TWO_THIRDS    2'h2
`define FMT_SUPPLY        2'h3
// ---------------------------------------------------------------
// power states
// ---------------------------------------------------------------
`define PWR_NORMAL        2'h0
`define PWR_HIZ           2'h1
`define PWR_NAP           2'h2
`define PWR_SLEEP         2'h3
// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define REG_STATUS        4'h0
`define REG_MASK          4'h1
`define REG_STATE         4'h2
`define REG_COUNT         4'h3
// ---------------------------------------------------------------
// status bit positions and reset values
// ---------------------------------------------------------------
`define ST_RANGE          0
`define ST_RESUME         1
`define ST_WIDTH          2
`define MASK_RESET        2'h0
`endif

// ### core/sync2.v
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// two-flop synchroniser, one per bit
// ---------------------------------------------------------------
module sync2 #(
	parameter WIDTH = 1
) (
	input  wire             ref_clk_i,
	input  wire             reset_i,
	input  wire [WIDTH-1:0] async_i,
	output wire [WIDTH-1:0] sync_o
);
	reg [WIDTH-1:0] meta_q;
	reg [WIDTH-1:0] sync_q;

	// first stage read only by second stage
	always @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			meta_q <= {WIDTH{1'b0}};
			sync_q <= {WIDTH{1'b0}};
		end else begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end
	assign sync_o = sync_q;
endmodule
`default_nettype wire

// ### tb/adc_port_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// port checker
// ----
module adc_port_sva #(
	parameter CODE_W = 10
) (
	input wire logic              ref_clk_i,
	input wire logic              reset_i,
	input wire logic              power_down_select_i,
	input wire logic              output_enable_n_i,
	input wire logic [1:0]        format_select_i,
	input wire logic              reg_read_i,
	input wire logic [7:0]        reg_rdata_o,
	input wire logic [CODE_W-1:0] sample_code_bits_o,
	input wire logic [CODE_W-1:0] sample_code_bits_oe_o,
	input wire logic              range_flag_o,
	input wire logic              range_flag_oe_o,
	input wire logic              data_valid_strobe_o,
	input wire logic              data_valid_strobe_oe_o,
	input wire logic              twos_complement_o,
	input wire logic              stabiliser_on_o,
	input wire logic [1:0]        power_state_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	property p_oe_state;
		$stable({power_down_select_i, output_enable_n_i})[*6]
			|-> range_flag_oe_o == !(power_down_select_i || output_enable_n_i);
	endproperty
	a_oe_state: assert property (p_oe_state) else $error("drivers disagree with pins");
	property p_oe_group;
		sample_code_bits_oe_o == {CODE_W{range_flag_oe_o}}
			&& data_valid_strobe_oe_o == range_flag_oe_o;
	endproperty
	a_oe_group: assert property (p_oe_group) else $error("output enables split");
	property p_pwr;
		$stable({power_down_select_i, output_enable_n_i})[*6]
			|-> power_state_o == {power_down_select_i, output_enable_n_i};
	endproperty
	a_pwr: assert property (p_pwr) else $error("power state decode wrong");
	property p_fmt;
		$stable(format_select_i)[*6] |-> twos_complement_o == format_select_i[1]
			&& stabiliser_on_o == (format_select_i[1] ^ format_select_i[0]);
	endproperty
	a_fmt: assert property (p_fmt) else $error("format decode wrong");
	property p_rdata;
		!$past(reg_read_i) |-> reg_rdata_o == 8'h00;
	endproperty
	a_rdata: assert property (p_rdata) else $error("read data outside slot");
	property p_word;
		$changed(sample_code_bits_o) |-> $rose(data_valid_strobe_o);
	endproperty
	a_word: assert property (p_word) else $error("word moved off strobe");
	property p_flag;
		$changed(range_flag_o) |-> $rose(data_valid_strobe_o);
	endproperty
	a_flag: assert property (p_flag) else $error("flag moved off strobe");
	property p_hi;
		$rose(data_valid_strobe_o) |-> data_valid_strobe_o[*3];
	endproperty
	a_hi: assert property (p_hi) else $error("strobe high too short");
	property p_lo;
		$fell(data_valid_strobe_o) |-> !data_valid_strobe_o[*3];
	endproperty
	a_lo: assert property (p_lo) else $error("strobe low too short");
	c_word: cover property ($fell(data_valid_strobe_o) && range_flag_o);
	c_nap: cover property (power_state_o == 2'h2);
	c_twos: cover property (twos_complement_o && stabiliser_on_o);
endmodule
bind adc_pipeline_output_port adc_port_sva #(.CODE_W(CODE_W)) u_adc_port_sva (
	.ref_clk_i(ref_clk_i),
	.reset_i(reset_i),
	.power_down_select_i(power_down_select_i),
	.output_enable_n_i(output_enable_n_i),
	.format_select_i(format_select_i),
	.reg_read_i(reg_read_i),
	.reg_rdata_o(reg_rdata_o),
	.sample_code_bits_o(sample_code_bits_o),
	.sample_code_bits_oe_o(sample_code_bits_oe_o),
	.range_flag_o(range_flag_o),
	.range_flag_oe_o(range_flag_oe_o),
	.data_valid_strobe_o(data_valid_strobe_o),
	.data_valid_strobe_oe_o(data_valid_strobe_oe_o),
	.twos_complement_o(twos_complement_o),
	.stabiliser_on_o(stabiliser_on_o),
	.power_state_o(power_state_o)
);
`default_nettype wire

// ### tb/capture_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// capture logic
// ----
module capture_model (
	input wire logic       strobe_i,
	input wire logic [9:0] code_i,
	input wire logic       flag_i,
	input wire logic       live_i,
	output var logic [9:0] word_o,
	output var logic       flag_o,
	output var logic [15:0] count_o
);
	initial count_o = 16'h0000;
	// latch on strobe fall, ignored while undriven
	always @(negedge strobe_i) begin
		if (live_i) begin
			word_o  <= code_i;
			flag_o  <= flag_i;
			count_o <= count_o + 16'h0001;
		end
	end
endmodule
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_port_map.vh"
module testbench;
	logic ref_clk_i = 1'b0, reset_i = 1'b1, enc_p = 1'b0, enc_m = 1'b1, over = 1'b0;
	logic under = 1'b0, pd = 1'b0, oe_n = 1'b0, wr_s = 1'b0, rd_s = 1'b0, chk = 1'b0;
	logic [9:0] code = 10'h000, enc_n = 10'h000, e, cw, cap_word;
	logic [1:0] fmt = 2'h0;
	logic [2:0] ph = 3'h0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdat = 8'h00, rdat;
	logic [9:0] sc, sc_oe;
	logic fl, fl_oe, st, st_oe, twos, stab, irq, cap_flag;
	logic [1:0] pst;
	logic [15:0] cap_cnt;
	int n_errors = 0, n_checks = 0;
	always #2 ref_clk_i = ~ref_clk_i;
	adc_pipeline_output_port u_adc_pipeline_output_port (.ref_clk_i(ref_clk_i),
		.reset_i(reset_i), .encode_pos_i(enc_p), .encode_neg_i(enc_m), .analog_code_i(code),
		.analog_over_i(over), .analog_under_i(under), .power_down_select_i(pd),
		.output_enable_n_i(oe_n), .format_select_i(fmt), .reg_addr_i(addr),
		.reg_wdata_i(wdat), .reg_write_i(wr_s), .reg_read_i(rd_s), .reg_rdata_o(rdat),
		.sample_code_bits_o(sc), .sample_code_bits_oe_o(sc_oe), .range_flag_o(fl),
		.range_flag_oe_o(fl_oe), .data_valid_strobe_o(st), .data_valid_strobe_oe_o(st_oe),
		.twos_complement_o(twos), .stabiliser_on_o(stab), .power_state_o(pst), .irq_o(irq));
	// undriven lines show the inverse, so stale data cannot pass
	assign cw = sc ~^ sc_oe;
	capture_model u_capture_model (.strobe_i(st ~^ st_oe), .code_i(cw), .flag_i(fl ~^ fl_oe),
		.live_i(fl_oe), .word_o(cap_word), .flag_o(cap_flag), .count_o(cap_cnt));
	// encode pins, 32 ns; core value = index of the next rise
	always @(posedge ref_clk_i) begin
		ph <= ph + 3'h1;
		if (ph == 3'h3) begin
			{enc_p, enc_m} <= 2'b10;
			enc_n <= enc_n + 10'h001;
		end
		if (ph == 3'h7) begin
			{enc_p, enc_m} <= 2'b01;
			code <= enc_n + 10'h001;
			over <= enc_n[3:0] == 4'h9;
			under <= enc_n[3:0] == 4'hA;
		end
	end
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic ncyc(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		{wr_s, addr, wdat} <= {1'b1, a, d};
		@(posedge ref_clk_i);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] x);
		@(posedge ref_clk_i);
		{rd_s, addr} <= {1'b1, a};
		@(posedge ref_clk_i);
		rd_s <= 1'b0;
		#1 check({8'h00, rdat}, {8'h00, x});
	endtask
	task automatic print_verdict;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// captured word is the sample of six rises back
	always @(cap_cnt) begin
		if (chk) begin
			e = enc_n - 10'h006;
			check({6'h00, cap_word}, {6'h00, e[9] ^ fmt[1], e[8:0]});
			check({15'h0000, cap_flag}, {15'h0000, e[3:1] == 3'h5});
		end
	end
	initial begin
		#40000 n_errors++;
		print_verdict();
	end
	initial begin
		ncyc(6);
		reset_i <= 1'b0;
		for (int f = 0; f < 4; f++) begin
			{chk, fmt} <= {1'b0, f[1:0]};
			ncyc(64);
			chk <= 1'b1;
			check({14'h0000, twos, stab}, {14'h0000, f[1], f[1] ^ f[0]});
			ncyc(80);
		end
		chk <= 1'b0;
		for (int s = 1; s < 4; s++) begin
			{pd, oe_n} <= s[1:0];
			ncyc(40);
			check({14'h0000, pst}, s[15:0]);
			check({5'h00, sc_oe, fl_oe}, 16'h0000);
		end
		{pd, oe_n} <= 2'b00;
		ncyc(56);
		check({5'h00, sc_oe, fl_oe}, 16'h07FF);
		chk <= 1'b1;
		ncyc(80);
		wr(`REG_MASK, 8'h02);
		ncyc(2);
		check({15'h0000, irq}, 16'h0001);
		wr(`REG_MASK, 8'h00);
		ncyc(2);
		check({15'h0000, irq}, 16'h0000);
		wr(`REG_MASK, 8'h02);
		wr(`REG_STATUS, 8'h02);
		ncyc(2);
		check({15'h0000, irq}, 16'h0000);
		rd(`REG_MASK, 8'h02);
		rd(4'hF, 8'h00);
		rd(`REG_STATUS, 8'h01);
		rd(`REG_STATE, 8'h04);
		print_verdict();
	end
endmodule
`default_nettype wire
